// ---- hdl/dcd_display_command_decoder.sv ----
// Summary of operation
// - Select low marks an opcode byte; select high marks parameter or RAM data.
// - Reset pin low returns every command setting to its default value.
// - Opcode 00h enables use of the loaded gray-scale table.
// - Opcode 15h takes start and end column, 0 to 119, default 0 and 119.
// - Opcode 75h takes start and end row, 0 to 127, default 0 and 127.
// - After 5Ch data bytes are stored into display RAM at the pointer.
// - After 5Dh host data reads return display RAM contents.
// - Opcode A1h sets the first RAM line shown, 0 to 127, default 0.
// - Opcode A2h sets vertical shift in scan rows, 0 to 127, default 0.
// - Opcode A4h forces every pixel to gray level 0.
// - Opcode A5h forces every pixel to gray level 15, except rows outside an active partial display.
// - Opcode A6h selects normal display, the mode after reset.
// - Opcode A7h shows stored level g as 15 minus g.
// - Opcode A8h with start and end row enters partial display.
// - Opcode A9h leaves partial display for full display.
`timescale 1ns/10ps
`default_nettype none
module dcd_display_command_decoder #(
  parameter int BUF_DEPTH = dcd_pkg::BUF_DEPTH
) (
  input wire logic CLK_SYS_IN, // 40 MHz system clock
  input wire logic RST_N_IN, // Chip init pin, synchronous, active low
  input wire logic HOST_DC_IN, // High data or parameter, low opcode
  input wire logic [dcd_pkg::DATA_W-1:0] HOST_DATA_IN, // Host write byte
  input wire logic HOST_WR_IN, // Host write strobe
  input wire logic HOST_RD_IN, // Host read strobe
  output logic [dcd_pkg::DATA_W-1:0] HOST_RDATA_OUT, // Read data, next cycle
  output logic HOST_READY_OUT, // Buffer can take a write byte
  output logic HOST_BUSY_OUT, // Bytes still wait for decoding
  input wire logic [dcd_pkg::ADDR_W-1:0] SCAN_COL_IN, // Scan column byte
  input wire logic [dcd_pkg::ADDR_W-1:0] SCAN_ROW_IN, // Scan row
  input wire logic SCAN_NIB_IN, // Low nibble when high
  output logic [dcd_pkg::GRAY_W-1:0] GRAY_LEVEL_OUT, // Shown gray level
  output logic [dcd_pkg::ADDR_W-1:0] COL_START_OUT, // Column window start
  output logic [dcd_pkg::ADDR_W-1:0] COL_END_OUT, // Column window end
  output logic [dcd_pkg::ADDR_W-1:0] ROW_START_OUT, // Row window start
  output logic [dcd_pkg::ADDR_W-1:0] ROW_END_OUT, // Row window end
  output logic [dcd_pkg::ADDR_W-1:0] START_LINE_OUT, // First line shown
  output logic [dcd_pkg::ADDR_W-1:0] DISP_OFFSET_OUT, // Vertical shift
  output logic [1:0] DISP_MODE_OUT, // Display mode
  output logic PARTIAL_EN_OUT, // Partial display active
  output logic [dcd_pkg::ADDR_W-1:0] PART_START_OUT, // Partial start row
  output logic [dcd_pkg::ADDR_W-1:0] PART_END_OUT, // Partial end row
  output logic GRAY_TABLE_EN_OUT // Gray-scale table in use
);
  import dcd_pkg::*;

  // ==========================================================
  // Declarations
  logic [DATA_W:0] buf_data;
  logic buf_valid;
  logic buf_ready;
  logic take;
  logic b_dc;
  logic [DATA_W-1:0] b_data;
  logic [ADDR_W-1:0] p7;
  logic rd_take;
  logic ram_we;
  logic ptr_step;
  logic [RAM_AW-1:0] ptr_idx;
  logic [RAM_AW-1:0] scan_idx;
  logic [ADDR_W-1:0] scan_ram_row;
  logic [DATA_W-1:0] scan_byte;
  logic [GRAY_W-1:0] stored_level;
  logic row_in_part;
  logic [GRAY_W-1:0] level_nxt;
  logic col_at_end;
  logic row_at_end;
  logic [ADDR_W-1:0] col_adv;
  logic [ADDR_W-1:0] row_adv;
  logic [DATA_W-1:0] ram_mem [0:(1<<RAM_AW)-1];

  dcd_state_t state_r, state_nxt;
  dcd_acc_t acc_r, acc_nxt;
  logic [ADDR_W-1:0] tmp_r, tmp_nxt;
  logic [ADDR_W-1:0] col_s_r, col_s_nxt;
  logic [ADDR_W-1:0] col_e_r, col_e_nxt;
  logic [ADDR_W-1:0] row_s_r, row_s_nxt;
  logic [ADDR_W-1:0] row_e_r, row_e_nxt;
  logic [ADDR_W-1:0] col_p_r, col_p_nxt;
  logic [ADDR_W-1:0] row_p_r, row_p_nxt;
  logic [ADDR_W-1:0] line_r, line_nxt;
  logic [ADDR_W-1:0] offs_r, offs_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic part_en_r, part_en_nxt;
  logic [ADDR_W-1:0] part_s_r, part_s_nxt;
  logic [ADDR_W-1:0] part_e_r, part_e_nxt;
  logic gray_en_r, gray_en_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [GRAY_W-1:0] level_r;

  // ==========================================================
  // Host byte buffer
  // The RAM has one host port, so a host read steals the cycle from
  // the decoder; back-to-back reads let the buffer fill.
  dcd_pair_buffer #(
    .WIDTH(DATA_W + 1),
    .DEPTH(BUF_DEPTH)
  ) dcd_pair_buffer_i (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RST_N_IN),
    .in_valid_in(HOST_WR_IN),
    .in_ready_out(HOST_READY_OUT),
    .in_data_in({HOST_DC_IN, HOST_DATA_IN}),
    .out_valid_out(buf_valid),
    .out_ready_in(buf_ready),
    .out_data_out(buf_data)
  );

  assign buf_ready = !HOST_RD_IN;
  assign take = buf_valid && buf_ready;
  assign b_dc = buf_data[DATA_W];
  assign b_data = buf_data[DATA_W-1:0];
  assign p7 = b_data[ADDR_W-1:0];
  assign HOST_BUSY_OUT = buf_valid;

  // ==========================================================
  // RAM pointer stepping
  assign rd_take = HOST_RD_IN && (acc_r == ACC_READ);
  assign ptr_step = ram_we || rd_take;
  assign ptr_idx = {row_p_r, col_p_r};
  assign col_at_end = (col_p_r == col_e_r);
  assign row_at_end = (row_p_r == row_e_r);
  assign col_adv = col_at_end ? col_s_r : col_p_r + 1'b1;
  assign row_adv = !col_at_end ? row_p_r :
                   (row_at_end ? row_s_r : row_p_r + 1'b1);

  // ==========================================================
  // Command decoding
  always_comb begin
    state_nxt = state_r;
    acc_nxt = acc_r;
    tmp_nxt = tmp_r;
    col_s_nxt = col_s_r;
    col_e_nxt = col_e_r;
    row_s_nxt = row_s_r;
    row_e_nxt = row_e_r;
    col_p_nxt = col_p_r;
    row_p_nxt = row_p_r;
    line_nxt = line_r;
    offs_nxt = offs_r;
    mode_nxt = mode_r;
    part_en_nxt = part_en_r;
    part_s_nxt = part_s_r;
    part_e_nxt = part_e_r;
    gray_en_nxt = gray_en_r;
    ram_we = 1'b0;
    if (take && !b_dc) begin
      // An opcode drops any unfinished parameters and any RAM access
      state_nxt = ST_IDLE;
      acc_nxt = ACC_NONE;
      case (b_data)
        OP_GRAY_EN: begin
          gray_en_nxt = 1'b1;
        end
        OP_COL_ADDR: begin
          state_nxt = ST_COL_A;
        end
        OP_RAM_WR: begin
          acc_nxt = ACC_WRITE;
        end
        OP_RAM_RD: begin
          acc_nxt = ACC_READ;
        end
        OP_ROW_ADDR: begin
          state_nxt = ST_ROW_A;
        end
        OP_REMAP: begin
          state_nxt = ST_SKIP2;
        end
        OP_START_LINE: begin
          state_nxt = ST_LINE;
        end
        OP_OFFSET: begin
          state_nxt = ST_OFFS;
        end
        OP_ALL_OFF, OP_ALL_ON, OP_NORMAL, OP_INVERSE: begin
          mode_nxt = b_data[1:0];
        end
        OP_PART_ON: begin
          state_nxt = ST_PART_A;
        end
        OP_PART_OFF: begin
          part_en_nxt = 1'b0;
        end
        default: begin
        end
      endcase
    end else if (take) begin
      case (state_r)
        ST_IDLE: begin
          ram_we = (acc_r == ACC_WRITE);
        end
        ST_COL_A: begin
          tmp_nxt = p7;
          state_nxt = ST_COL_B;
        end
        ST_COL_B: begin
          col_s_nxt = tmp_r;
          col_e_nxt = p7;
          col_p_nxt = tmp_r;
          state_nxt = ST_IDLE;
        end
        ST_ROW_A: begin
          tmp_nxt = p7;
          state_nxt = ST_ROW_B;
        end
        ST_ROW_B: begin
          row_s_nxt = tmp_r;
          row_e_nxt = p7;
          row_p_nxt = tmp_r;
          state_nxt = ST_IDLE;
        end
        ST_LINE: begin
          line_nxt = p7;
          state_nxt = ST_IDLE;
        end
        ST_OFFS: begin
          offs_nxt = p7;
          state_nxt = ST_IDLE;
        end
        ST_PART_A: begin
          tmp_nxt = p7;
          state_nxt = ST_PART_B;
        end
        ST_PART_B: begin
          // End below start is the host's fault and shows no rows
          part_s_nxt = tmp_r;
          part_e_nxt = p7;
          part_en_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
        ST_SKIP2: begin
          state_nxt = ST_SKIP1;
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
    if (ptr_step) begin
      col_p_nxt = col_adv;
      row_p_nxt = row_adv;
    end
  end

  // ==========================================================
  // State registers
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      state_r <= ST_IDLE;
      acc_r <= ACC_NONE;
      tmp_r <= '0;
      col_s_r <= COL_START_RST;
      col_e_r <= COL_END_RST;
      row_s_r <= ROW_START_RST;
      row_e_r <= ROW_END_RST;
      col_p_r <= COL_START_RST;
      row_p_r <= ROW_START_RST;
      line_r <= START_LINE_RST;
      offs_r <= OFFSET_RST;
      mode_r <= MODE_NORMAL;
      part_en_r <= 1'b0;
      part_s_r <= ROW_START_RST;
      part_e_r <= ROW_END_RST;
      gray_en_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      acc_r <= acc_nxt;
      tmp_r <= tmp_nxt;
      col_s_r <= col_s_nxt;
      col_e_r <= col_e_nxt;
      row_s_r <= row_s_nxt;
      row_e_r <= row_e_nxt;
      col_p_r <= col_p_nxt;
      row_p_r <= row_p_nxt;
      line_r <= line_nxt;
      offs_r <= offs_nxt;
      mode_r <= mode_nxt;
      part_en_r <= part_en_nxt;
      part_s_r <= part_s_nxt;
      part_e_r <= part_e_nxt;
      gray_en_r <= gray_en_nxt;
    end
  end

  // ==========================================================
  // Display RAM
  // RAM contents survive reset, as a real frame buffer does
  always_ff @(posedge CLK_SYS_IN) begin
    if (ram_we) begin
      ram_mem[ptr_idx] <= b_data;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      rdata_r <= RDATA_RST;
    end else if (rd_take) begin
      rdata_r <= ram_mem[ptr_idx];
    end else if (HOST_RD_IN) begin
      rdata_r <= RDATA_RST;
    end
  end

  // ==========================================================
  // Pixel output
  // The vertical shift is handed to the row driver, not applied here
  assign scan_ram_row = SCAN_ROW_IN + line_r;
  assign scan_idx = {scan_ram_row, SCAN_COL_IN};
  assign scan_byte = ram_mem[scan_idx];
  assign stored_level = SCAN_NIB_IN ? scan_byte[3:0] : scan_byte[7:4];
  assign row_in_part = (SCAN_ROW_IN >= part_s_r) && (SCAN_ROW_IN <= part_e_r);

  always_comb begin
    case (mode_r)
      MODE_ALL_OFF: level_nxt = GRAY_MIN;
      MODE_ALL_ON: level_nxt = GRAY_MAX;
      MODE_INVERSE: level_nxt = GRAY_MAX - stored_level;
      default: level_nxt = stored_level;
    endcase
    if (part_en_r && !row_in_part) begin
      level_nxt = GRAY_MIN;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      level_r <= GRAY_MIN;
    end else begin
      level_r <= level_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign HOST_RDATA_OUT = rdata_r;
  assign GRAY_LEVEL_OUT = level_r;
  assign COL_START_OUT = col_s_r;
  assign COL_END_OUT = col_e_r;
  assign ROW_START_OUT = row_s_r;
  assign ROW_END_OUT = row_e_r;
  assign START_LINE_OUT = line_r;
  assign DISP_OFFSET_OUT = offs_r;
  assign DISP_MODE_OUT = mode_r;
  assign PARTIAL_EN_OUT = part_en_r;
  assign PART_START_OUT = part_s_r;
  assign PART_END_OUT = part_e_r;
  assign GRAY_TABLE_EN_OUT = gray_en_r;
endmodule
`default_nettype wire

// ---- hdl/dcd_pkg.sv ----
`default_nettype none
package dcd_pkg;
  // ==========================================================
  // Widths and geometry
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int GRAY_W = 4;
  localparam int RAM_AW = 2 * ADDR_W;
  localparam int BUF_DEPTH = 2;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_GRAY_EN = 8'h00;
  localparam logic [7:0] OP_COL_ADDR = 8'h15;
  localparam logic [7:0] OP_RAM_WR = 8'h5C;
  localparam logic [7:0] OP_RAM_RD = 8'h5D;
  localparam logic [7:0] OP_ROW_ADDR = 8'h75;
  localparam logic [7:0] OP_REMAP = 8'hA0;
  localparam logic [7:0] OP_START_LINE = 8'hA1;
  localparam logic [7:0] OP_OFFSET = 8'hA2;
  localparam logic [7:0] OP_ALL_OFF = 8'hA4;
  localparam logic [7:0] OP_ALL_ON = 8'hA5;
  localparam logic [7:0] OP_NORMAL = 8'hA6;
  localparam logic [7:0] OP_INVERSE = 8'hA7;
  localparam logic [7:0] OP_PART_ON = 8'hA8;
  localparam logic [7:0] OP_PART_OFF = 8'hA9;
  // ==========================================================
  // Display modes, equal to the low two bits of opcodes A4h to A7h
  localparam logic [1:0] MODE_ALL_OFF = 2'h0;
  localparam logic [1:0] MODE_ALL_ON = 2'h1;
  localparam logic [1:0] MODE_NORMAL = 2'h2;
  localparam logic [1:0] MODE_INVERSE = 2'h3;
  // ==========================================================
  // Reset values
  localparam logic [6:0] COL_START_RST = 7'h00;
  localparam logic [6:0] COL_END_RST = 7'h77;
  localparam logic [6:0] ROW_START_RST = 7'h00;
  localparam logic [6:0] ROW_END_RST = 7'h7F;
  localparam logic [6:0] START_LINE_RST = 7'h00;
  localparam logic [6:0] OFFSET_RST = 7'h00;
  localparam logic [3:0] GRAY_MAX = 4'hF;
  localparam logic [3:0] GRAY_MIN = 4'h0;
  localparam logic [7:0] RDATA_RST = 8'h00;
  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_IDLE, ST_COL_A, ST_COL_B, ST_ROW_A, ST_ROW_B, ST_LINE, ST_OFFS,
    ST_PART_A, ST_PART_B, ST_SKIP2, ST_SKIP1
  } dcd_state_t;
  typedef enum logic [1:0] {ACC_NONE, ACC_WRITE, ACC_READ} dcd_acc_t;
endpackage
`default_nettype wire

// ---- hdl/dcd_pair_buffer.sv ----
`timescale 1ns/10ps
`default_nettype none
module dcd_pair_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic clk_in, // System clock
  input wire logic rst_n_in, // Synchronous reset, active low
  input wire logic in_valid_in, // Entry offered
  output logic in_ready_out, // Room for an entry
  input wire logic [WIDTH-1:0] in_data_in, // Entry data
  output logic out_valid_out, // Entry available
  input wire logic out_ready_in, // Drain takes entry
  output logic [WIDTH-1:0] out_data_out // Oldest entry
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] slot_r [0:DEPTH-1];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic push;
  logic pop;
  logic [PW-1:0] wr_ptr_nxt;
  logic [PW-1:0] rd_ptr_nxt;
  logic [CW-1:0] count_nxt;

  assign in_ready_out = (count_r != FULL);
  assign out_valid_out = (count_r != '0);
  assign out_data_out = slot_r[rd_ptr_r];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign wr_ptr_nxt = (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
  assign rd_ptr_nxt = (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
  assign count_nxt = count_r + CW'(push) - CW'(pop);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_nxt;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_nxt;
      end
      count_r <= count_nxt;
    end
  end

  // Data slots need no reset; valid gates them
  always_ff @(posedge clk_in) begin
    if (push) begin
      slot_r[wr_ptr_r] <= in_data_in;
    end
  end
endmodule
`default_nettype wire

// ---- tb/dcd_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module dcd_host_model (
  input wire logic clk_in, // Device clock
  input wire logic ready_in, // Device can take a byte
  input wire logic [7:0] rdata_in, // Read data
  output logic dc_out, // Low opcode, high data
  output logic [7:0] data_out, // Write byte
  output logic wr_out, // Write strobe
  output logic rd_out // Read strobe
);
  initial begin
    dc_out = 1'b0;
    data_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // ==========================================================
  // Bus cycles
  // Strobe stays high across back-to-back bytes, so only idle() and get() drop it
  task automatic put(input logic dc, input logic [7:0] b);
    dc_out <= dc;
    data_out <= b;
    wr_out <= 1'b1;
    rd_out <= 1'b0;
    do @(posedge clk_in); while (ready_in !== 1'b1);
  endtask
  task automatic idle();
    wr_out <= 1'b0;
    data_out <= ~data_out; // A released bus must not keep showing the last byte
    @(posedge clk_in);
  endtask
  task automatic get(output logic [7:0] b);
    dc_out <= 1'b1;
    wr_out <= 1'b0;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    @(posedge clk_in);
    b = rdata_in;
  endtask
endmodule
`default_nettype wire

// ---- tb/dcd_decoder_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module dcd_decoder_sva
  import dcd_pkg::*;
(
  input wire logic CLK_SYS_IN, // Clock
  input wire logic RST_N_IN, // Reset, active low
  input wire logic HOST_WR_IN, // Write strobe
  input wire logic HOST_RD_IN, // Read strobe
  input wire logic [7:0] HOST_RDATA_OUT, // Read data
  input wire logic HOST_READY_OUT, // Buffer room
  input wire logic HOST_BUSY_OUT, // Bytes pending
  input wire logic [6:0] SCAN_ROW_IN, // Scan row
  input wire logic [3:0] GRAY_LEVEL_OUT, // Shown level
  input wire logic [6:0] COL_START_OUT, // Column start
  input wire logic [6:0] COL_END_OUT, // Column end
  input wire logic [6:0] ROW_END_OUT, // Row end
  input wire logic [1:0] DISP_MODE_OUT, // Mode
  input wire logic PARTIAL_EN_OUT, // Partial on
  input wire logic [6:0] PART_START_OUT, // Partial start
  input wire logic [6:0] PART_END_OUT, // Partial end
  input wire logic GRAY_TABLE_EN_OUT // Table in use
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  // ==========================================================
  // Properties
  property p_rst;
    disable iff (1'b0) !RST_N_IN |=> COL_START_OUT == COL_START_RST && COL_END_OUT == COL_END_RST
      && ROW_END_OUT == ROW_END_RST && DISP_MODE_OUT == MODE_NORMAL && !PARTIAL_EN_OUT
      && !GRAY_TABLE_EN_OUT && HOST_RDATA_OUT == RDATA_RST && !HOST_BUSY_OUT;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_gtab;
    disable iff (!RST_N_IN) RST_N_IN && GRAY_TABLE_EN_OUT |=> GRAY_TABLE_EN_OUT;
  endproperty
  a_gtab: assert property (p_gtab) else $error("gray table enable dropped");
  property p_off;
    disable iff (!RST_N_IN) DISP_MODE_OUT == MODE_ALL_OFF |=> GRAY_LEVEL_OUT == GRAY_MIN;
  endproperty
  a_off: assert property (p_off) else $error("all off not dark");
  property p_on;
    disable iff (!RST_N_IN) RST_N_IN && DISP_MODE_OUT == MODE_ALL_ON && !PARTIAL_EN_OUT
      |=> GRAY_LEVEL_OUT == GRAY_MAX;
  endproperty
  a_on: assert property (p_on) else $error("all on not full");
  property p_part;
    disable iff (!RST_N_IN) PARTIAL_EN_OUT
      && (SCAN_ROW_IN < PART_START_OUT || SCAN_ROW_IN > PART_END_OUT) |=> GRAY_LEVEL_OUT == 0;
  endproperty
  a_part: assert property (p_part) else $error("row outside partial lit");
  property p_quiet;
    disable iff (!RST_N_IN) RST_N_IN && !HOST_BUSY_OUT
      |=> $stable(COL_START_OUT) && $stable(ROW_END_OUT)
      && $stable(DISP_MODE_OUT) && $stable(PARTIAL_EN_OUT);
  endproperty
  a_quiet: assert property (p_quiet) else $error("setting moved with no byte");
  property p_rhold;
    disable iff (!RST_N_IN) RST_N_IN && !HOST_RD_IN |=> $stable(HOST_RDATA_OUT);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data moved without read");
  property p_wbusy;
    disable iff (!RST_N_IN) HOST_WR_IN && HOST_READY_OUT |=> HOST_BUSY_OUT;
  endproperty
  a_wbusy: assert property (p_wbusy) else $error("taken byte not pending");
  property p_ready;
    disable iff (!RST_N_IN) !HOST_BUSY_OUT |-> HOST_READY_OUT;
  endproperty
  a_ready: assert property (p_ready) else $error("empty buffer not ready");
  c_part: cover property (PARTIAL_EN_OUT ##1 !PARTIAL_EN_OUT);
  c_inv: cover property (DISP_MODE_OUT == MODE_INVERSE);
  c_rd: cover property (HOST_RD_IN ##1 HOST_RDATA_OUT != 0);
endmodule
bind dcd_display_command_decoder dcd_decoder_sva dcd_decoder_sva_i (
  .CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN), .HOST_WR_IN(HOST_WR_IN),
  .HOST_RD_IN(HOST_RD_IN), .HOST_RDATA_OUT(HOST_RDATA_OUT), .HOST_READY_OUT(HOST_READY_OUT),
  .HOST_BUSY_OUT(HOST_BUSY_OUT), .SCAN_ROW_IN(SCAN_ROW_IN), .GRAY_LEVEL_OUT(GRAY_LEVEL_OUT),
  .COL_START_OUT(COL_START_OUT), .COL_END_OUT(COL_END_OUT), .ROW_END_OUT(ROW_END_OUT),
  .DISP_MODE_OUT(DISP_MODE_OUT), .PARTIAL_EN_OUT(PARTIAL_EN_OUT),
  .PART_START_OUT(PART_START_OUT), .PART_END_OUT(PART_END_OUT),
  .GRAY_TABLE_EN_OUT(GRAY_TABLE_EN_OUT));
`default_nettype wire

// ---- tb/dcd_display_command_decoder_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module dcd_display_command_decoder_bench;
  import dcd_pkg::*;
  logic clk, rst_n, nib, ready, busy, part_en, gtab;
  wire dc;
  wire wr;
  wire rd;
  wire [7:0] data;
  logic [7:0] rdata;
  logic [6:0] scol, srow, cs, ce, rs, re, sl, offs, ps, pe;
  logic [3:0] gray;
  logic [1:0] mode;
  int fails = 0;
  int check_count = 0;
  dcd_display_command_decoder dcd_display_command_decoder_i (
    .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .HOST_DC_IN(dc), .HOST_DATA_IN(data),
    .HOST_WR_IN(wr), .HOST_RD_IN(rd), .HOST_RDATA_OUT(rdata), .HOST_READY_OUT(ready),
    .HOST_BUSY_OUT(busy), .SCAN_COL_IN(scol), .SCAN_ROW_IN(srow), .SCAN_NIB_IN(nib),
    .GRAY_LEVEL_OUT(gray), .COL_START_OUT(cs), .COL_END_OUT(ce), .ROW_START_OUT(rs),
    .ROW_END_OUT(re), .START_LINE_OUT(sl), .DISP_OFFSET_OUT(offs), .DISP_MODE_OUT(mode),
    .PARTIAL_EN_OUT(part_en), .PART_START_OUT(ps), .PART_END_OUT(pe),
    .GRAY_TABLE_EN_OUT(gtab));
  dcd_host_model dcd_host_model_i (.clk_in(clk), .ready_in(ready), .rdata_in(rdata),
    .dc_out(dc), .data_out(data), .wr_out(wr), .rd_out(rd));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================
  // Shared helpers
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  // Outputs are read at an edge before its updates land, so they show the settled cycle
  task automatic cmd(input logic [7:0] op, input int n = 0, input logic [7:0] a = 8'h00,
      input logic [7:0] b = 8'h00);
    int i;
    dcd_host_model_i.put(1'b0, op);
    if (n > 0) dcd_host_model_i.put(1'b1, a);
    if (n > 1) dcd_host_model_i.put(1'b1, b);
    dcd_host_model_i.idle();
    i = 0;
    do @(posedge clk); while (busy !== 1'b0 && ++i < 20);
    chk(32'(busy), 32'(1'b0));
  endtask
  task automatic scan(input logic [6:0] row, input logic n, input logic [3:0] exp);
    scol <= 7'h05;
    srow <= row;
    nib <= n;
    repeat (2) @(posedge clk);
    chk(32'(gray), 32'(exp));
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk(32'({cs, ce}), 32'({COL_START_RST, COL_END_RST}));
    chk(32'({rs, re}), 32'({ROW_START_RST, ROW_END_RST}));
    chk(32'({sl, offs}), 32'({START_LINE_RST, OFFSET_RST}));
    chk(32'({mode, part_en, gtab}), 32'({MODE_NORMAL, 2'b00}));
  endtask
  task automatic t_ram();
    logic [7:0] w[5] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9A};
    logic [7:0] b;
    cmd(OP_COL_ADDR, 2, 8'h85, 8'h06);
    cmd(OP_ROW_ADDR, 2, 8'h02, 8'h83);
    chk(32'({cs, ce, rs, re}), 32'({7'h05, 7'h06, 7'h02, 7'h03}));
    dcd_host_model_i.put(1'b0, OP_RAM_WR);
    for (int i = 0; i < 5; i++) dcd_host_model_i.put(1'b1, w[i]);
    cmd(OP_COL_ADDR, 1, 8'h30);
    chk(32'({cs, ce}), 32'({7'h05, 7'h06}));
    cmd(OP_COL_ADDR, 2, 8'h05, 8'h06);
    cmd(OP_ROW_ADDR, 2, 8'h02, 8'h03);
    cmd(OP_RAM_RD);
    w[0] = 8'h9A; // Fifth byte wrapped onto the window start
    for (int i = 0; i < 4; i++) begin
      dcd_host_model_i.get(b);
      chk(32'(b), 32'(w[i]));
    end
  endtask
  task automatic t_modes();
    logic [7:0] ops[4] = '{OP_INVERSE, OP_ALL_OFF, OP_ALL_ON, OP_NORMAL};
    logic [3:0] lv[4] = '{4'h6, 4'h0, 4'hF, 4'h9};
    cmd(OP_START_LINE, 1, 8'h82);
    chk(32'(sl), 32'(7'h02));
    scan(7'h00, 1'b1, 4'hA);
    for (int i = 0; i < 4; i++) begin
      cmd(ops[i]);
      chk(32'(mode), 32'(ops[i][1:0]));
      scan(7'h00, 1'b0, lv[i]);
    end
  endtask
  task automatic t_partial();
    cmd(OP_ALL_ON);
    cmd(OP_PART_ON, 2, 8'h01, 8'h01);
    chk(32'({part_en, ps, pe}), 32'({1'b1, 7'h01, 7'h01}));
    scan(7'h00, 1'b0, 4'h0);
    scan(7'h01, 1'b0, 4'hF);
    cmd(OP_PART_OFF);
    chk(32'(part_en), 32'(1'b0));
    scan(7'h00, 1'b0, 4'hF);
    dcd_host_model_i.put(1'b1, OP_ALL_OFF);
    cmd(OP_OFFSET, 1, 8'hFF);
    chk(32'({mode, offs}), 32'({MODE_ALL_ON, 7'h7F}));
    cmd(OP_GRAY_EN);
    chk(32'(gtab), 32'(1'b1));
  endtask
  initial begin
    rst_n = 1'b0;
    scol = 7'h00;
    srow = 7'h00;
    nib = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_ram();
    t_modes();
    t_partial();
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    close_out();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule
`default_nettype wire
